// *** sbs_pkg.sv ***
package sbs_pkg;
	// Overview of operation
	// RQ1: Status code held in upper five bits.
	// RQ2: Code valid only while event flag set.
	// RQ3: Low three bits read zero when flagged.
	// RQ4: Software never writes the status register.
	// RQ5: Reset and idle code 0xF8, no flag.
	// RQ6: Master start 0x08, repeated start 0x10.
	// RQ7: Write address sent: ack 0x18, nack 0x20.
	// RQ8: Master data sent: ack 0x28, nack 0x30.
	// RQ9: Arbitration lost 0x38; addressed 0x68, 0x78.
	// RQ10: Lost arbitration, own read address 0xB0.
	// RQ11: Read address sent: ack 0x40, nack 0x48.
	// RQ12: Master receive: ack 0x50, nack 0x58.
	// RQ13: Own write address acknowledged gives 0x60.
	// RQ14: General call acknowledged gives 0x70.
	// RQ15: Slave data received: ack 0x80, nack 0x88.
	// RQ16: General call data: ack 0x90, nack 0x98.
	// RQ17: Stop or repeated start as slave 0xA0.
	// RQ18: Slave transmit: 0xA8, then 0xB8 or 0xC0.
	// RQ19: Last byte acked with assert clear 0xC8.
	// RQ20: Clock high too long gives 0xD0.
	// RQ21: Misplaced start or stop gives 0x00.
	// RQ22: Software sets halt request to recover.
	// RQ23: Software sets halt plus begin to poll.
	// RQ24: Event flag set by hardware, cleared by software.
	// RQ25: Acknowledge drives data low when assert set.
	// RQ26: Slave halt request acts as received stop.
	// RQ27: Code loads in same cycle as flag.

	// ------------------------------------------------
	// Register map and fields
	// ------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_CTRL = 8'hC0;
	localparam logic [7:0] IDX_CODE = 8'hC1;
	localparam logic [7:0] IDX_DATA = 8'hC2;
	localparam logic [7:0] IDX_ADDR = 8'hC3;
	localparam logic [7:0] IDX_RATE = 8'hCF;
	localparam logic [11:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
	localparam logic [11:0] A_CODE = {2'h0, IDX_CODE, 2'h0};
	localparam logic [11:0] A_DATA = {2'h0, IDX_DATA, 2'h0};
	localparam logic [11:0] A_ADDR = {2'h0, IDX_ADDR, 2'h0};
	localparam logic [11:0] A_RATE = {2'h0, IDX_RATE, 2'h0};
	localparam int B_BUSY = 7;
	localparam int B_ENABLE = 6;
	localparam int B_BEGIN = 5;
	localparam int B_HALT = 4;
	localparam int B_FLAG = 3;
	localparam int B_ACK = 2;
	localparam int B_FREE_TO = 1;
	localparam int B_LOW_TO = 0;

	// ------------------------------------------------
	// Phase codes and timing
	// ------------------------------------------------
	localparam logic [7:0] CODE_START = 8'h08;
	localparam logic [7:0] CODE_RSTART = 8'h10;
	localparam logic [7:0] CODE_MT_ADR_ACK = 8'h18;
	localparam logic [7:0] CODE_MT_ADR_NACK = 8'h20;
	localparam logic [7:0] CODE_MT_DAT_ACK = 8'h28;
	localparam logic [7:0] CODE_MT_DAT_NACK = 8'h30;
	localparam logic [7:0] CODE_ARB_LOST = 8'h38;
	localparam logic [7:0] CODE_MR_ADR_ACK = 8'h40;
	localparam logic [7:0] CODE_MR_ADR_NACK = 8'h48;
	localparam logic [7:0] CODE_MR_DAT_ACK = 8'h50;
	localparam logic [7:0] CODE_MR_DAT_NACK = 8'h58;
	localparam logic [7:0] CODE_SR_ADR = 8'h60;
	localparam logic [7:0] CODE_SR_ADR_ARB = 8'h68;
	localparam logic [7:0] CODE_SR_GC = 8'h70;
	localparam logic [7:0] CODE_SR_GC_ARB = 8'h78;
	localparam logic [7:0] CODE_SR_DAT_ACK = 8'h80;
	localparam logic [7:0] CODE_SR_DAT_NACK = 8'h88;
	localparam logic [7:0] CODE_SR_GCD_ACK = 8'h90;
	localparam logic [7:0] CODE_SR_GCD_NACK = 8'h98;
	localparam logic [7:0] CODE_SR_STOP = 8'hA0;
	localparam logic [7:0] CODE_TX_ADR = 8'hA8;
	localparam logic [7:0] CODE_TX_ADR_ARB = 8'hB0;
	localparam logic [7:0] CODE_TX_DAT_ACK = 8'hB8;
	localparam logic [7:0] CODE_TX_DAT_NACK = 8'hC0;
	localparam logic [7:0] CODE_TX_LAST_ACK = 8'hC8;
	localparam logic [7:0] CODE_FREE_TO = 8'hD0;
	localparam logic [7:0] CODE_BUS_ERR = 8'h00;
	localparam logic [7:0] CODE_IDLE = 8'hF8;
	localparam logic [3:0] FREE_TICKS = 4'hA;

	// ------------------------------------------------
	// Engine state and register set
	// ------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_START = 5'b00010,
		ST_BYTE = 5'b00100,
		ST_HOLD = 5'b01000,
		ST_STOP = 5'b10000
	} sbs_state_e;

	typedef struct packed {
		sbs_state_e st;
		logic [1:0] step;
		logic scl_a, scl_b, scl_c, sda_a, sda_b, sda_c;
		logic busy, enable, begin_req, halt_req, si, ack_assert, free_to_en, low_to_en;
		logic [4:0] phase_code_bits;
		logic [7:0] shift_byte_reg, own_addr, scl_rate_preset, tmr;
		logic [3:0] ftk, bcnt;
		logic mst, tx, addr_ph, dir, slv, gc, arb, rd, last_nack, rep, ack_rx;
		logic scl_low, sda_low;
		logic [31:0] prdata;
		logic pready, pslverr;
	} sbs_regs_s;

	localparam sbs_regs_s RST = '{st: ST_IDLE, phase_code_bits: CODE_IDLE[7:3], scl_a: 1'h1, scl_b: 1'h1,
		scl_c: 1'h1, sda_a: 1'h1, sda_b: 1'h1, sda_c: 1'h1, default: '0};
endpackage

// *** sbs_smbus_status_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
module sbs_smbus_status_unit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sbs_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic event_flag
);
	sbs_pkg::sbs_regs_s q, n;
	logic scl_rise, scl_fall, bus_start, bus_stop, tick, wr;

	// ------------------------------------------------
	// Line events and rate divider
	// ------------------------------------------------
	assign scl_rise = q.scl_b & ~q.scl_c;
	assign scl_fall = ~q.scl_b & q.scl_c;
	assign bus_start = q.scl_b & q.scl_c & q.sda_c & ~q.sda_b;
	assign bus_stop = q.scl_b & q.scl_c & ~q.sda_c & q.sda_b;
	assign tick = q.enable & (q.tmr == 8'hFF);
	assign wr = psel & penable & q.pready & pwrite;

	// Next-state logic
	always_comb begin
		logic ev;
		logic [7:0] ev_code;
		logic [7:0] ctrl;
		logic own_m, gc_m;
		ev = 1'h0;
		ev_code = sbs_pkg::CODE_IDLE;
		ctrl = 8'h00;
		own_m = 1'h0;
		gc_m = 1'h0;
		n = q;
		// Two-stage pin synchronisers, third stage for edges
		n.scl_a = scl_i;
		n.scl_b = q.scl_a;
		n.scl_c = q.scl_b;
		n.sda_a = sda_i;
		n.sda_b = q.sda_a;
		n.sda_c = q.sda_b;
		// Divider preloaded from the rate preset
		n.tmr = tick ? q.scl_rate_preset : q.tmr + 8'h01;
		// Clock-high counter for the free timeout
		if (~q.scl_b | ~q.busy) begin
			n.ftk = 4'h0;
		end else if (tick & (q.ftk != sbs_pkg::FREE_TICKS)) begin
			n.ftk = q.ftk + 4'h1;
		end
		if (bus_start) begin
			n.busy = 1'h1;
		end
		if (bus_stop) begin
			n.busy = 1'h0;
			n.halt_req = 1'h0;
		end

		// APB read data and error in the setup cycle
		ctrl[sbs_pkg::B_BUSY] = q.busy;
		ctrl[sbs_pkg::B_ENABLE] = q.enable;
		ctrl[sbs_pkg::B_BEGIN] = q.begin_req;
		ctrl[sbs_pkg::B_HALT] = q.halt_req;
		ctrl[sbs_pkg::B_FLAG] = q.si;
		ctrl[sbs_pkg::B_ACK] = q.ack_assert;
		ctrl[sbs_pkg::B_FREE_TO] = q.free_to_en;
		ctrl[sbs_pkg::B_LOW_TO] = q.low_to_en;
		n.pready = psel & ~penable;
		n.pslverr = 1'h0;
		if (psel & ~penable) begin
			n.prdata = 32'h0;
			case (paddr)
				sbs_pkg::A_CTRL: n.prdata[7:0] = ctrl;
				sbs_pkg::A_CODE: n.prdata[7:0] = {q.phase_code_bits, 3'h0}; // RQ1 RQ3
				sbs_pkg::A_DATA: n.prdata[7:0] = q.shift_byte_reg;
				sbs_pkg::A_ADDR: n.prdata[7:0] = q.own_addr;
				sbs_pkg::A_RATE: n.prdata[7:0] = q.scl_rate_preset;
				default: n.pslverr = 1'h1;
			endcase
		end
		// APB writes on the access edge; the status code is read-only
		if (wr) begin
			case (paddr)
				sbs_pkg::A_CTRL: begin
					n.enable = pwdata[sbs_pkg::B_ENABLE];
					n.begin_req = pwdata[sbs_pkg::B_BEGIN];
					n.halt_req = pwdata[sbs_pkg::B_HALT];
					n.si = pwdata[sbs_pkg::B_FLAG]; // RQ24
					n.ack_assert = pwdata[sbs_pkg::B_ACK];
					n.free_to_en = pwdata[sbs_pkg::B_FREE_TO];
					n.low_to_en = pwdata[sbs_pkg::B_LOW_TO];
				end
				sbs_pkg::A_DATA: n.shift_byte_reg = pwdata[7:0];
				sbs_pkg::A_ADDR: n.own_addr = pwdata[7:0];
				sbs_pkg::A_RATE: n.scl_rate_preset = pwdata[7:0];
				default: ; // RQ4
			endcase
		end

		// ------------------------------------------------
		// Bus engine
		// ------------------------------------------------
		unique case (q.st)
			sbs_pkg::ST_IDLE: begin
				n.scl_low = 1'h0;
				n.sda_low = 1'h0;
				n.mst = 1'h0;
				n.slv = 1'h0;
				if (q.halt_req) begin
					// Software recovery frees the interface
					n.halt_req = 1'h0; // RQ22
					n.busy = bus_start; // A start in the same cycle still marks the bus busy
				end else if (q.begin_req & ~q.busy) begin
					n.st = sbs_pkg::ST_START;
					n.step = 2'h0;
					n.rep = 1'h0;
				end else if (bus_start) begin
					n.st = sbs_pkg::ST_BYTE;
					n.bcnt = 4'h0;
					n.addr_ph = 1'h1;
					n.tx = 1'h0;
					n.arb = 1'h0;
				end
			end
			sbs_pkg::ST_START: begin
				// Release data, release clock, pull data, pull clock
				unique case (q.step)
					2'h0: begin
						n.sda_low = 1'h0;
						if (tick) begin
							n.scl_low = 1'h0;
							n.step = 2'h1;
						end
					end
					2'h1: if (tick & q.scl_b & q.sda_b) begin
						n.sda_low = 1'h1;
						n.step = 2'h2;
					end
					default: if (tick) begin
						n.scl_low = 1'h1;
						n.step = 2'h0;
						n.st = sbs_pkg::ST_HOLD;
						n.mst = 1'h1;
						n.slv = 1'h0;
						n.tx = 1'h1;
						n.addr_ph = 1'h1;
						n.arb = 1'h0;
						n.bcnt = 4'h0;
						ev = 1'h1;
						ev_code = q.rep ? sbs_pkg::CODE_RSTART : sbs_pkg::CODE_START; // RQ6
					end
				endcase
			end
			sbs_pkg::ST_HOLD: begin
				// Clock held low until software clears the event flag
				n.scl_low = 1'h1;
				if (~q.si) begin
					if (q.halt_req & q.mst) begin
						n.st = sbs_pkg::ST_STOP;
						n.step = 2'h0;
					end else if (q.halt_req) begin
						n.halt_req = 1'h0; // RQ26
						n.slv = 1'h0;
						n.scl_low = 1'h0;
						n.st = sbs_pkg::ST_IDLE;
					end else if (q.begin_req & q.mst) begin
						n.st = sbs_pkg::ST_START;
						n.step = 2'h0;
						n.rep = 1'h1;
					end else begin
						n.st = sbs_pkg::ST_BYTE;
						n.bcnt = 4'h0;
						n.sda_low = q.tx & ~q.shift_byte_reg[7];
						n.last_nack = ~q.ack_assert;
						if (q.mst & q.addr_ph) begin
							n.dir = q.shift_byte_reg[0];
						end
						if (~q.mst) begin
							n.scl_low = 1'h0;
						end
					end
				end
			end
			sbs_pkg::ST_STOP: begin
				// Pull data, release clock, release data
				unique case (q.step)
					2'h0: begin
						n.sda_low = 1'h1;
						if (tick) begin
							n.scl_low = 1'h0;
							n.step = 2'h1;
						end
					end
					2'h1: if (tick & q.scl_b) begin
						n.sda_low = 1'h0;
						n.step = 2'h2;
					end
					default: if (tick) begin
						n.halt_req = 1'h0;
						n.mst = 1'h0;
						n.step = 2'h0;
						n.rep = 1'h0;
						n.st = q.begin_req ? sbs_pkg::ST_START : sbs_pkg::ST_IDLE;
					end
				endcase
			end
			default: begin
				// Master clock generation, waiting while stretched
				if (q.mst) begin
					if (tick & q.scl_low) begin
						n.scl_low = 1'h0;
					end else if (tick & q.scl_b) begin
						n.scl_low = 1'h1;
					end
					if (~q.scl_low & ~q.scl_b) begin
						n.tmr = q.scl_rate_preset;
					end
				end
				if (scl_rise) begin
					if (q.bcnt == 4'h8) begin
						n.ack_rx = ~q.sda_b;
					end else begin
						n.shift_byte_reg = {q.shift_byte_reg[6:0], q.sda_b};
						if (q.mst & q.tx & ~q.sda_low & ~q.sda_b) begin
							n.mst = 1'h0;
							n.scl_low = 1'h0;
							n.arb = 1'h1;
							n.tx = 1'h0;
							if (~q.addr_ph) begin
								ev = 1'h1;
								ev_code = sbs_pkg::CODE_ARB_LOST; // RQ9
								n.st = sbs_pkg::ST_IDLE;
							end
						end
					end
				end else if (scl_fall & (q.bcnt != 4'h8)) begin
					n.bcnt = q.bcnt + 4'h1;
					if (q.bcnt != 4'h7) begin
						n.sda_low = q.tx & ~q.shift_byte_reg[7];
					end else if (q.tx) begin
						n.sda_low = 1'h0;
					end else if (q.mst | q.slv) begin
						n.sda_low = q.ack_assert; // RQ25 RQ12
					end else begin
						own_m = q.shift_byte_reg[7:1] == q.own_addr[7:1];
						gc_m = (q.shift_byte_reg == 8'h00) & q.own_addr[0];
						n.sda_low = q.ack_assert & (own_m | gc_m); // RQ25
						n.slv = q.ack_assert & (own_m | gc_m);
						n.gc = ~own_m;
						n.rd = own_m & q.shift_byte_reg[0];
					end
				end else if (scl_fall) begin
					// Byte and acknowledge complete
					n.bcnt = 4'h0;
					n.sda_low = 1'h0;
					n.addr_ph = 1'h0;
					n.st = sbs_pkg::ST_HOLD;
					n.scl_low = 1'h1;
					ev = 1'h1;
					if (q.mst & q.addr_ph) begin
						n.tx = ~q.dir;
						if (q.dir) begin
							ev_code = q.ack_rx ? sbs_pkg::CODE_MR_ADR_ACK : sbs_pkg::CODE_MR_ADR_NACK; // RQ11
						end else begin
							ev_code = q.ack_rx ? sbs_pkg::CODE_MT_ADR_ACK : sbs_pkg::CODE_MT_ADR_NACK; // RQ7
						end
					end else if (q.mst & q.tx) begin
						ev_code = q.ack_rx ? sbs_pkg::CODE_MT_DAT_ACK : sbs_pkg::CODE_MT_DAT_NACK; // RQ8
					end else if (q.mst) begin
						ev_code = q.ack_rx ? sbs_pkg::CODE_MR_DAT_ACK : sbs_pkg::CODE_MR_DAT_NACK; // RQ12
					end else if (q.slv & q.addr_ph) begin
						n.tx = q.rd;
						if (q.rd) begin
							ev_code = q.arb ? sbs_pkg::CODE_TX_ADR_ARB : sbs_pkg::CODE_TX_ADR; // RQ10 RQ18
						end else if (q.gc) begin
							ev_code = q.arb ? sbs_pkg::CODE_SR_GC_ARB : sbs_pkg::CODE_SR_GC; // RQ9 RQ14
						end else begin
							ev_code = q.arb ? sbs_pkg::CODE_SR_ADR_ARB : sbs_pkg::CODE_SR_ADR; // RQ9 RQ13
						end
					end else if (q.slv & q.tx) begin
						if (~q.ack_rx) begin
							ev_code = sbs_pkg::CODE_TX_DAT_NACK; // RQ18
						end else if (q.last_nack) begin
							ev_code = sbs_pkg::CODE_TX_LAST_ACK; // RQ19
						end else begin
							ev_code = sbs_pkg::CODE_TX_DAT_ACK; // RQ18
						end
						if (~q.ack_rx | q.last_nack) begin
							n.slv = 1'h0;
							n.tx = 1'h0;
							n.scl_low = 1'h0;
							n.st = sbs_pkg::ST_IDLE;
						end
					end else if (q.slv) begin
						if (q.gc) begin
							ev_code = q.ack_rx ? sbs_pkg::CODE_SR_GCD_ACK : sbs_pkg::CODE_SR_GCD_NACK; // RQ16
						end else begin
							ev_code = q.ack_rx ? sbs_pkg::CODE_SR_DAT_ACK : sbs_pkg::CODE_SR_DAT_NACK; // RQ15
						end
						if (~q.ack_rx) begin
							n.slv = 1'h0;
							n.scl_low = 1'h0;
							n.st = sbs_pkg::ST_IDLE;
						end
					end else begin
						// Not addressed: silent unless arbitration was lost
						ev = q.arb;
						ev_code = sbs_pkg::CODE_ARB_LOST; // RQ9
						n.scl_low = 1'h0;
						n.st = sbs_pkg::ST_IDLE;
					end
				end
			end
		endcase

		// Start or stop seen on the bus during a transfer
		if (((q.st == sbs_pkg::ST_BYTE) || (q.st == sbs_pkg::ST_HOLD)) & (bus_start | bus_stop)) begin
			if ((q.mst | q.slv) & (q.bcnt != 4'h0)) begin
				ev = 1'h1;
				ev_code = sbs_pkg::CODE_BUS_ERR; // RQ21
				n.st = sbs_pkg::ST_IDLE;
			end else if (q.slv) begin
				ev = 1'h1;
				ev_code = sbs_pkg::CODE_SR_STOP; // RQ17
				n.st = bus_start ? sbs_pkg::ST_BYTE : sbs_pkg::ST_IDLE;
			end else if (~q.mst) begin
				n.st = bus_start ? sbs_pkg::ST_BYTE : sbs_pkg::ST_IDLE;
			end
			if (~q.mst | (q.bcnt != 4'h0)) begin
				n.mst = 1'h0;
				n.slv = 1'h0;
				n.tx = 1'h0;
				n.arb = 1'h0;
				n.addr_ph = 1'h1;
				n.bcnt = 4'h0;
				n.scl_low = 1'h0;
				n.sda_low = 1'h0;
			end
		end
		// Clock held high too long while the bus is busy
		if (tick & q.free_to_en & q.busy & q.scl_b & (q.ftk == sbs_pkg::FREE_TICKS - 4'h1)
			& (q.st != sbs_pkg::ST_START) & (q.st != sbs_pkg::ST_STOP)) begin
			ev = 1'h1;
			ev_code = sbs_pkg::CODE_FREE_TO; // RQ20
			n.st = sbs_pkg::ST_IDLE;
			n.mst = 1'h0;
			n.slv = 1'h0;
			n.scl_low = 1'h0;
			n.sda_low = 1'h0;
		end
		// Disabled interface releases the bus
		if (~q.enable) begin
			ev = 1'h0;
			n.st = sbs_pkg::ST_IDLE;
			n.mst = 1'h0;
			n.slv = 1'h0;
			n.busy = 1'h0;
			n.scl_low = 1'h0;
			n.sda_low = 1'h0;
		end
		// Flag set wins over a software clear; code loads with it
		if (ev) begin
			n.si = 1'h1; // RQ24 RQ2
			n.phase_code_bits = ev_code[7:3]; // RQ27 RQ1 RQ3
		end else if ((n.st == sbs_pkg::ST_IDLE) & ~n.si) begin
			n.phase_code_bits = sbs_pkg::CODE_IDLE[7:3]; // RQ5
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= sbs_pkg::RST; // RQ5
		end else begin
			q <= n;
		end
	end

	// Outputs straight from the state register; scl_o and sda_o tied low
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign scl_o = 1'h0;
	assign scl_oe = q.scl_low;
	assign sda_o = 1'h0;
	assign sda_oe = q.sda_low;
	assign event_flag = q.si;
endmodule
`default_nettype wire

// *** sbs_status_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module sbs_status_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sbs_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_o,
	input wire logic sda_o,
	input wire logic event_flag
);
	// Bus phase decodes
	wire logic setup = psel && !penable;
	wire logic code_rd = setup && !pwrite && paddr == sbs_pkg::A_CODE;
	wire logic flag_clr = psel && penable && pready && pwrite && paddr == sbs_pkg::A_CTRL && !pwdata[sbs_pkg::B_FLAG];
	wire logic mapped = paddr inside {sbs_pkg::A_CTRL, sbs_pkg::A_CODE, sbs_pkg::A_DATA, sbs_pkg::A_ADDR,
		sbs_pkg::A_RATE};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Handshake timing
	property p_ready_after_setup; setup |=> pready; endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready missing after setup");
	property p_no_stray_ready; !setup |=> !pready; endproperty
	a_no_stray_ready: assert property (p_no_stray_ready) else $error("pready without setup");
	property p_ready_single; pready |=> !pready; endproperty
	a_ready_single: assert property (p_ready_single) else $error("pready longer than one cycle");
	property p_unmapped; setup && !mapped |=> pslverr && prdata == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_mapped; setup && mapped |=> !pslverr && prdata[31:8] == 24'h0; endproperty
	a_mapped: assert property (p_mapped) else $error("mapped access flagged or wide");
	// Status code, event flag and line drive
	property p_low_zero; code_rd && event_flag |=> prdata[2:0] == 3'h0; endproperty
	a_low_zero: assert property (p_low_zero) else $error("status low bits set with flag");
	property p_no_idle_flag; code_rd && event_flag |=> prdata[7:0] != 8'hF8; endproperty
	a_no_idle_flag: assert property (p_no_idle_flag) else $error("idle code with flag set");
	property p_flag_hold; event_flag && !flag_clr |=> event_flag; endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("event flag dropped by hardware");
	property p_open_drain; scl_o == 1'b0 && sda_o == 1'b0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("line driven high");
	// Main scenarios seen
	c_flag: cover property ($rose(event_flag));
	c_refuse: cover property (pready && pslverr);
	c_code_rd: cover property (code_rd && event_flag);
endmodule
bind sbs_smbus_status_unit sbs_status_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .scl_o, .sda_o, .event_flag);
`default_nettype wire

// *** sbs_slave_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module sbs_slave_model #(
	parameter logic [6:0] ADDR = 7'h5A
) (
	input wire logic scl,
	input wire logic sda,
	output logic sda_oe
);
	logic [7:0] sh;
	logic [7:0] tx;
	logic act, rd, adr;
	int cnt;
	initial begin
		sda_oe = 0;
		act = 0;
		adr = 0;
		cnt = 0;
	end
	// Start and stop conditions
	always @(negedge sda) if (scl) begin
		act = 1;
		adr = 1;
		rd = 0;
		cnt = -1;
		tx = 8'hB2; // Advanced once by the address ack
	end
	always @(posedge sda) if (scl) act = 0;
	// Sample data and master acknowledge
	always @(posedge scl) begin
		if (act && cnt >= 0 && cnt < 8) sh = {sh[6:0], sda};
		if (act && rd && cnt == 8) begin
			act = !sda;
			tx = tx + 8'h11;
		end
	end
	// Drive acknowledge or read data while clock low
	always @(negedge scl) begin
		cnt = (cnt == 8) ? 0 : cnt + 1;
		if (act && adr && cnt == 8) begin
			act = sh[7:1] == ADDR;
			rd = sh[0];
			adr = 0;
			sda_oe = act;
		end else if (!act) sda_oe = 0;
		else if (cnt == 8) sda_oe = !rd;
		else sda_oe = rd && !tx[7 - cnt];
	end
endmodule
`default_nettype wire

// *** smbus_status_code_unit_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module smbus_status_code_unit_tb;
	localparam logic [6:0] SLV = 7'h5A;
	localparam logic [11:0] AC = sbs_pkg::A_CTRL;
	localparam logic [11:0] AS = sbs_pkg::A_CODE;
	localparam logic [11:0] AD = sbs_pkg::A_DATA;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, event_flag, m_oe, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, lfsr;
	logic [7:0] wb;
	logic tb_sda;
	int num_errors, n_compared;
	logic [7:0] exp_q[$];
	// Open-drain wires with pull-ups; the bench may also pull data low
	wire logic scl_w = !scl_oe;
	wire logic sda_w = !(sda_oe || m_oe || tb_sda);
	sbs_smbus_status_unit u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda_w), .sda_o, .sda_oe, .event_flag);
	sbs_slave_model #(.ADDR(SLV)) u_slv (.scl(scl_w), .sda(sda_w), .sda_oe(m_oe));
	initial begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end
	task automatic results();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stuck();
		num_errors++;
		$display("CHECK FAILED %0t wait ran out", $time);
		results();
	endtask
	// Random source for stimulus
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// APB transfer, held until pready sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) stuck();
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Load data, write control, then await the reported code
	task automatic step(input logic [7:0] dat, input logic [7:0] ctl, input logic [7:0] code);
		int n;
		apb(1, AD, {24'h0, dat});
		apb(1, AC, {24'h0, ctl});
		n = 0;
		// Flag clear lands at the access edge; look from the next edge on
		do begin
			@(posedge pclk);
			n++;
		end while (event_flag !== 1'b1 && n < 5000);
		if (n >= 5000) stuck();
		apb(0, AS, 0);
		chk({1'b0, rd}, {25'h0, code});
	endtask
	// Stop request, then idle state checks
	task automatic halt();
		int n;
		apb(1, AC, 32'h50);
		n = 0;
		do begin
			apb(0, AC, 0);
			n++;
		end while (rd[4] !== 1'b0 && n < 500);
		if (n >= 500) stuck();
		apb(0, AS, 0);
		chk({1'b0, rd}, 33'hF8);
		chk({32'h0, event_flag}, 33'h0);
	endtask
	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		tb_sda = 0;
		num_errors = 0;
		n_compared = 0;
		lfsr = 32'h93C460C8;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		// Reset state, read-only status, unmapped access
		apb(0, AS, 0);
		chk({event_flag, rd}, 33'hF8);
		apb(1, AS, 32'h55);
		apb(0, AS, 0);
		chk({1'b0, rd}, 33'hF8);
		apb(0, 12'h000, 32'h0);
		chk({err, rd}, {1'b1, 32'h0});
		apb(1, sbs_pkg::A_RATE, 32'hFC);
		// Address not acknowledged, write and read direction, then polled again
		for (int i = 0; i < 2; i++) begin
			step(8'h00, 8'h60, 8'h08);
			step({7'h11, i[0]}, 8'h40, i ? 8'h48 : 8'h20);
			step(8'h00, 8'h70, 8'h08);
			halt();
		end
		// Master write with random data, then repeated start and read
		for (int i = 0; i < 8; i++) lfsr = lfsr_next(lfsr);
		wb = lfsr[7:0];
		exp_q.push_back(8'hC3);
		exp_q.push_back(8'hD4);
		step({SLV, 1'b0}, 8'h60, 8'h08);
		step({SLV, 1'b0}, 8'h40, 8'h18);
		step(wb, 8'h40, 8'h28);
		apb(0, AD, 0);
		chk({1'b0, rd}, {25'h0, wb});
		step(wb, 8'h60, 8'h10);
		step({SLV, 1'b1}, 8'h44, 8'h40);
		step(8'h00, 8'h44, 8'h50);
		apb(0, AD, 0);
		chk({1'b0, rd}, {25'h0, exp_q.pop_front()});
		step(8'h00, 8'h40, 8'h58);
		apb(0, AD, 0);
		chk({1'b0, rd}, {25'h0, exp_q.pop_front()});
		halt();
		// Data line pulled with the clock high: busy bus, clock-high timeout
		apb(1, AC, 32'h42);
		tb_sda <= 1'b1;
		step(8'h00, 8'h42, 8'hD0);
		tb_sda <= 1'b0;
		halt();
		results();
	end
endmodule
`default_nettype wire
